// ==== hdl/iet_pkg.sv ====
// iet_pkg: constants and types of the interrupt entry timing model
// assumes a single core clock; all counts are in core clocks
package iet_pkg;
  // opcodes
  localparam logic [7:0] OP_SOFT_INT = 8'hcd;
  localparam logic [7:0] OP_BREAKPOINT = 8'hcc;
  localparam logic [7:0] OVERFLOW_TRAP_OP = 8'hce;
  localparam logic [7:0] OP_BOUNDS = 8'h62;
  localparam logic [7:0] INTERRUPT_RETURN_OP = 8'hcf;
  // vectors
  localparam logic [7:0] VEC_BREAKPOINT = 8'h03;
  localparam logic [7:0] VEC_OVERFLOW = 8'h04;
  localparam logic [7:0] VEC_BOUNDS = 8'h05;
  // extra clocks on top of the entry value; the not-taken overflow and in-range bounds costs stand alone
  localparam logic [9:0] EXT_SOFT_RV = 10'h004;
  localparam logic [9:0] EXT_SOFT_P = 10'h000;
  localparam logic [9:0] EXT_BREAKPOINT = 10'h000;
  localparam logic [9:0] EXT_OVERFLOW = 10'h002;
  localparam logic [9:0] CLK_OVERFLOW_NOT_TAKEN = 10'h003;
  localparam logic [9:0] CLK_BOUNDS_IN = 10'h007;
  localparam logic [9:0] PEN_BOUNDS = 10'h007;
  localparam logic [9:0] EXT_BOUNDS_OUT = 10'h018;
  localparam logic [9:0] EXT_EXTERNAL = 10'h00b;
  localparam logic [9:0] EXT_NMI = 10'h003;
  localparam logic [9:0] EXT_PAGE_FAULT = 10'h018;
  // interrupt return
  localparam logic [9:0] CLK_RET_RV = 10'h00f;
  localparam logic [9:0] PEN_RET_RV = 10'h008;
  localparam logic [9:0] CLK_RET_SAME = 10'h014;
  localparam logic [9:0] PEN_RET_SAME = 10'h00b;
  localparam logic [9:0] CLK_RET_OUTER = 10'h024;
  localparam logic [9:0] PEN_RET_OUTER = 10'h013;
  localparam logic [9:0] CLK_RET_NESTED = 10'h020;
  localparam logic [9:0] PEN_RET_NESTED = 10'h004;
  // task switch
  localparam logic [9:0] CLK_TS_32 = 10'h0a2;
  localparam logic [9:0] PEN_TS_32 = 10'h037;
  localparam logic [9:0] CLK_TS_16 = 10'h08f;
  localparam logic [9:0] PEN_TS_16 = 10'h01f;
  localparam logic [9:0] CLK_TS_V86 = 10'h08c;
  localparam logic [9:0] PEN_TS_V86 = 10'h025;
  // entry value
  localparam logic [9:0] CLK_INT_REAL = 10'h01a;
  localparam logic [9:0] PEN_INT_REAL = 10'h002;
  localparam logic [9:0] CLK_INT_SAME = 10'h02c;
  localparam logic [9:0] PEN_INT_SAME = 10'h006;
  localparam logic [9:0] CLK_INT_DIFF = 10'h047;
  localparam logic [9:0] PEN_INT_DIFF = 10'h011;
  localparam logic [9:0] CLK_INT_V86_DIFF = 10'h052;
  localparam logic [9:0] PEN_INT_V86_DIFF = 10'h011;
  localparam logic [9:0] CLK_INT_TASK = 10'h025;
  localparam logic [9:0] PEN_INT_TASK = 10'h003;

  typedef enum logic [1:0] {
    IET_MODE_REAL = 2'b00,
    IET_MODE_PROT = 2'b01,
    IET_MODE_V86 = 2'b10
  } iet_mode_e;

  typedef enum logic [1:0] {
    IET_GATE_SAME = 2'b00,
    IET_GATE_DIFF = 2'b01,
    IET_GATE_TASK = 2'b10
  } iet_gate_e;

  typedef enum logic [1:0] {
    IET_TSS_32 = 2'b00,
    IET_TSS_16 = 2'b01,
    IET_TSS_V86 = 2'b10
  } iet_tss_e;

  typedef enum logic [2:0] {
    IET_EV_NONE = 3'b000,
    IET_EV_EXTERNAL = 3'b001,
    IET_EV_NMI = 3'b010,
    IET_EV_PAGE_FAULT = 3'b011
  } iet_event_e;

  // request context
  typedef struct packed {
    iet_mode_e mode;
    iet_gate_e gate;
    iet_tss_e task_state_segment;
    logic overflow_flag;
    logic nested_task_flag;
    logic ret_outer;
    logic bounds_out;
    logic cache_miss;
  } iet_ctx_s;

  // result
  typedef struct packed {
    logic [9:0] clocks;
    logic [7:0] vector;
    logic taken;
    logic is_return;
    logic bad_op;
  } iet_res_s;
endpackage

// ==== hdl/iet_timing.sv ====
// iet_timing: decodes interrupt-class opcodes and events, reports latency
// assumes requests come from core logic on i_clk; a request is a one-cycle pulse
module iet_timing (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // instruction request
  input wire logic i_op_valid,
  input wire logic [7:0] i_opcode,
  input wire logic [7:0] i_type,
  // asynchronous-class event request
  input wire logic i_ev_valid,
  input wire iet_pkg::iet_event_e i_event,
  // context
  input wire iet_pkg::iet_ctx_s i_ctx,
  // result
  output logic o_done,
  output iet_pkg::iet_res_s o_res
);

  // hit plus optional miss penalty
  function automatic logic [9:0] f_cost(input logic [9:0] hit, input logic [9:0] pen, input logic miss);
    f_cost = miss ? 10'(hit + pen) : hit;
  endfunction

  logic [9:0] ts_clocks;
  logic [9:0] int_clocks;
  logic [9:0] ret_clocks;
  iet_pkg::iet_res_s nxt_res;
  logic nxt_done;
  logic done_ff;
  iet_pkg::iet_res_s res_ff;

  // task switch cost
  always_comb begin
    case (i_ctx.task_state_segment)
      iet_pkg::IET_TSS_16: ts_clocks = f_cost(iet_pkg::CLK_TS_16, iet_pkg::PEN_TS_16, i_ctx.cache_miss);
      iet_pkg::IET_TSS_V86: ts_clocks = f_cost(iet_pkg::CLK_TS_V86, iet_pkg::PEN_TS_V86, i_ctx.cache_miss);
      default: ts_clocks = f_cost(iet_pkg::CLK_TS_32, iet_pkg::PEN_TS_32, i_ctx.cache_miss);
    endcase
  end

  // entry value
  always_comb begin
    int_clocks = f_cost(iet_pkg::CLK_INT_REAL, iet_pkg::PEN_INT_REAL, i_ctx.cache_miss);
    if (i_ctx.mode != iet_pkg::IET_MODE_REAL && i_ctx.gate == iet_pkg::IET_GATE_TASK) begin
      int_clocks = 10'(f_cost(iet_pkg::CLK_INT_TASK, iet_pkg::PEN_INT_TASK, i_ctx.cache_miss) + ts_clocks);
    end else if (i_ctx.mode == iet_pkg::IET_MODE_V86) begin
      // v86 always enters through an outer-level gate
      int_clocks = f_cost(iet_pkg::CLK_INT_V86_DIFF, iet_pkg::PEN_INT_V86_DIFF, i_ctx.cache_miss);
    end else if (i_ctx.mode == iet_pkg::IET_MODE_PROT) begin
      if (i_ctx.gate == iet_pkg::IET_GATE_DIFF) begin
        int_clocks = f_cost(iet_pkg::CLK_INT_DIFF, iet_pkg::PEN_INT_DIFF, i_ctx.cache_miss);
      end else begin
        int_clocks = f_cost(iet_pkg::CLK_INT_SAME, iet_pkg::PEN_INT_SAME, i_ctx.cache_miss);
      end
    end
  end

  // return cost
  always_comb begin
    ret_clocks = f_cost(iet_pkg::CLK_RET_RV, iet_pkg::PEN_RET_RV, i_ctx.cache_miss);
    if (i_ctx.mode == iet_pkg::IET_MODE_PROT) begin
      if (i_ctx.nested_task_flag) begin
        ret_clocks = 10'(f_cost(iet_pkg::CLK_RET_NESTED, iet_pkg::PEN_RET_NESTED, i_ctx.cache_miss) + ts_clocks);
      end else if (i_ctx.ret_outer) begin
        ret_clocks = f_cost(iet_pkg::CLK_RET_OUTER, iet_pkg::PEN_RET_OUTER, i_ctx.cache_miss);
      end else begin
        ret_clocks = f_cost(iet_pkg::CLK_RET_SAME, iet_pkg::PEN_RET_SAME, i_ctx.cache_miss);
      end
    end
  end

  // decode; events take priority over an instruction in the same cycle
  always_comb begin
    nxt_res = '0;
    nxt_done = 1'b0;
    if (i_ev_valid) begin
      nxt_done = 1'b1;
      nxt_res.taken = 1'b1;
      case (i_event)
        iet_pkg::IET_EV_EXTERNAL: nxt_res.clocks = 10'(int_clocks + iet_pkg::EXT_EXTERNAL);
        iet_pkg::IET_EV_NMI: nxt_res.clocks = 10'(int_clocks + iet_pkg::EXT_NMI);
        iet_pkg::IET_EV_PAGE_FAULT: nxt_res.clocks = 10'(int_clocks + iet_pkg::EXT_PAGE_FAULT);
        default: begin
          nxt_res.taken = 1'b0;
          nxt_res.bad_op = 1'b1;
        end
      endcase
    end else if (i_op_valid) begin
      nxt_done = 1'b1;
      case (i_opcode)
        iet_pkg::OP_SOFT_INT: begin
          nxt_res.taken = 1'b1;
          nxt_res.vector = i_type;
          nxt_res.clocks = (i_ctx.mode == iet_pkg::IET_MODE_PROT) ?
            10'(int_clocks + iet_pkg::EXT_SOFT_P) : 10'(int_clocks + iet_pkg::EXT_SOFT_RV);
        end
        iet_pkg::OP_BREAKPOINT: begin
          nxt_res.taken = 1'b1;
          nxt_res.vector = iet_pkg::VEC_BREAKPOINT;
          nxt_res.clocks = 10'(int_clocks + iet_pkg::EXT_BREAKPOINT);
        end
        iet_pkg::OVERFLOW_TRAP_OP: begin
          if (i_ctx.overflow_flag) begin
            nxt_res.taken = 1'b1;
            nxt_res.vector = iet_pkg::VEC_OVERFLOW;
            nxt_res.clocks = 10'(int_clocks + iet_pkg::EXT_OVERFLOW);
          end else begin
            nxt_res.clocks = iet_pkg::CLK_OVERFLOW_NOT_TAKEN;
          end
        end
        iet_pkg::OP_BOUNDS: begin
          if (i_ctx.bounds_out) begin
            nxt_res.taken = 1'b1;
            nxt_res.vector = iet_pkg::VEC_BOUNDS;
            nxt_res.clocks = 10'(int_clocks + iet_pkg::EXT_BOUNDS_OUT);
          end else begin
            nxt_res.clocks = f_cost(iet_pkg::CLK_BOUNDS_IN, iet_pkg::PEN_BOUNDS, i_ctx.cache_miss);
          end
        end
        iet_pkg::INTERRUPT_RETURN_OP: begin
          nxt_res.is_return = 1'b1;
          nxt_res.clocks = ret_clocks;
        end
        default: nxt_res.bad_op = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      res_ff <= '0;
    end else begin
      res_ff <= nxt_res;
    end
  end

  assign o_done = done_ff;
  assign o_res = res_ff;

  // plain opcode request with no event
  sequence s_op(logic [7:0] op);
    i_op_valid && !i_ev_valid && i_opcode == op;
  endsequence

  property p_soft_int;
    @(posedge i_clk) disable iff (!i_resetn)
    s_op(iet_pkg::OP_SOFT_INT) |=> o_done && o_res.taken && o_res.vector == $past(i_type) &&
      o_res.clocks == ($past(i_ctx.mode) == iet_pkg::IET_MODE_PROT ? $past(int_clocks) : 10'($past(int_clocks) + 10'h004));
  endproperty
  a_soft_int: assert property (p_soft_int) else $error("soft interrupt cost wrong");

  property p_breakpoint;
    @(posedge i_clk) disable iff (!i_resetn)
    s_op(iet_pkg::OP_BREAKPOINT) |=> o_res.vector == 8'h03 && o_res.clocks == $past(int_clocks);
  endproperty
  a_breakpoint: assert property (p_breakpoint) else $error("breakpoint cost wrong");

  property p_overflow_clear;
    @(posedge i_clk) disable iff (!i_resetn)
    s_op(iet_pkg::OVERFLOW_TRAP_OP) ##0 !i_ctx.overflow_flag |=> !o_res.taken && o_res.clocks == 10'h003;
  endproperty
  a_overflow_clear: assert property (p_overflow_clear) else $error("overflow not-taken cost wrong");

  property p_bounds_in;
    @(posedge i_clk) disable iff (!i_resetn)
    s_op(iet_pkg::OP_BOUNDS) ##0 !i_ctx.bounds_out |=>
      o_res.clocks == ($past(i_ctx.cache_miss) ? 10'h00e : 10'h007);
  endproperty
  a_bounds_in: assert property (p_bounds_in) else $error("bounds in-range cost wrong");

  property p_ret_rv;
    @(posedge i_clk) disable iff (!i_resetn)
    s_op(iet_pkg::INTERRUPT_RETURN_OP) ##0 i_ctx.mode != iet_pkg::IET_MODE_PROT |=>
      o_res.is_return && o_res.clocks == ($past(i_ctx.cache_miss) ? 10'h017 : 10'h00f);
  endproperty
  a_ret_rv: assert property (p_ret_rv) else $error("real return cost wrong");

  property p_ret_outer;
    @(posedge i_clk) disable iff (!i_resetn)
    s_op(iet_pkg::INTERRUPT_RETURN_OP) ##0 i_ctx.mode == iet_pkg::IET_MODE_PROT && !i_ctx.nested_task_flag &&
      i_ctx.ret_outer && !i_ctx.cache_miss |=> o_res.clocks == 10'h024;
  endproperty
  a_ret_outer: assert property (p_ret_outer) else $error("outer return cost wrong");

  property p_nmi;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ev_valid && i_event == iet_pkg::IET_EV_NMI |=> o_done && o_res.clocks == 10'($past(int_clocks) + 10'h003);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi cost wrong");

  property p_ts32;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ctx.task_state_segment == iet_pkg::IET_TSS_32 && !i_ctx.cache_miss |-> ts_clocks == 10'h0a2;
  endproperty
  a_ts32: assert property (p_ts32) else $error("task switch cost wrong");

  property p_prot_same;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ctx.mode == iet_pkg::IET_MODE_PROT && i_ctx.gate == iet_pkg::IET_GATE_SAME && i_ctx.cache_miss |->
      int_clocks == 10'h032;
  endproperty
  a_prot_same: assert property (p_prot_same) else $error("protected entry cost wrong");

  property p_real_entry;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ctx.mode == iet_pkg::IET_MODE_REAL && !i_ctx.cache_miss |-> int_clocks == 10'h01a;
  endproperty
  a_real_entry: assert property (p_real_entry) else $error("real entry cost wrong");

  property p_idle;
    @(posedge i_clk) disable iff (!i_resetn)
    !i_op_valid && !i_ev_valid |=> !o_done;
  endproperty
  a_idle: assert property (p_idle) else $error("done without request");

  // event request of one kind
  sequence s_ev(iet_pkg::iet_event_e ev);
    i_ev_valid && i_event == ev;
  endsequence

  // protected return with no nested task
  sequence s_ret_flat;
    s_op(iet_pkg::INTERRUPT_RETURN_OP) ##0 i_ctx.mode == iet_pkg::IET_MODE_PROT && !i_ctx.nested_task_flag;
  endsequence

  property p_overflow_set;
    @(posedge i_clk) disable iff (!i_resetn)
    s_op(iet_pkg::OVERFLOW_TRAP_OP) ##0 i_ctx.overflow_flag |=>
      o_res.taken && o_res.vector == 8'h04 && o_res.clocks == 10'($past(int_clocks) + 10'h002);
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("overflow taken cost wrong");

  property p_bounds_out;
    @(posedge i_clk) disable iff (!i_resetn)
    s_op(iet_pkg::OP_BOUNDS) ##0 i_ctx.bounds_out |=>
      o_res.taken && o_res.vector == 8'h05 && o_res.clocks == 10'($past(int_clocks) + 10'h018);
  endproperty
  a_bounds_out: assert property (p_bounds_out) else $error("bounds out-of-range cost wrong");

  property p_ret_same;
    @(posedge i_clk) disable iff (!i_resetn)
    s_ret_flat ##0 !i_ctx.ret_outer |=>
      o_res.is_return && o_res.clocks == ($past(i_ctx.cache_miss) ? 10'h01f : 10'h014);
  endproperty
  a_ret_same: assert property (p_ret_same) else $error("same-level return cost wrong");

  property p_ret_outer_miss;
    @(posedge i_clk) disable iff (!i_resetn)
    s_ret_flat ##0 i_ctx.ret_outer && i_ctx.cache_miss |=> o_res.clocks == 10'h037;
  endproperty
  a_ret_outer_miss: assert property (p_ret_outer_miss) else $error("outer return miss cost wrong");

  property p_ret_nested;
    @(posedge i_clk) disable iff (!i_resetn)
    s_op(iet_pkg::INTERRUPT_RETURN_OP) ##0 i_ctx.mode == iet_pkg::IET_MODE_PROT && i_ctx.nested_task_flag &&
      !i_ctx.cache_miss |=> o_res.is_return && o_res.clocks == 10'($past(ts_clocks) + 10'h020);
  endproperty
  a_ret_nested: assert property (p_ret_nested) else $error("nested return cost wrong");

  property p_external;
    @(posedge i_clk) disable iff (!i_resetn)
    s_ev(iet_pkg::IET_EV_EXTERNAL) |=> o_done && o_res.taken && o_res.clocks == 10'($past(int_clocks) + 10'h00b);
  endproperty
  a_external: assert property (p_external) else $error("external interrupt cost wrong");

  property p_page_fault;
    @(posedge i_clk) disable iff (!i_resetn)
    s_ev(iet_pkg::IET_EV_PAGE_FAULT) |=> o_done && o_res.taken && o_res.clocks == 10'($past(int_clocks) + 10'h018);
  endproperty
  a_page_fault: assert property (p_page_fault) else $error("page fault cost wrong");

  property p_ts16;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ctx.task_state_segment == iet_pkg::IET_TSS_16 |-> ts_clocks == (i_ctx.cache_miss ? 10'h0ae : 10'h08f);
  endproperty
  a_ts16: assert property (p_ts16) else $error("16-bit task switch cost wrong");

  property p_ts_v86;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ctx.task_state_segment == iet_pkg::IET_TSS_V86 |-> ts_clocks == (i_ctx.cache_miss ? 10'h0b1 : 10'h08c);
  endproperty
  a_ts_v86: assert property (p_ts_v86) else $error("v86 task switch cost wrong");

  property p_prot_diff;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ctx.mode == iet_pkg::IET_MODE_PROT && i_ctx.gate == iet_pkg::IET_GATE_DIFF |->
      int_clocks == (i_ctx.cache_miss ? 10'h058 : 10'h047);
  endproperty
  a_prot_diff: assert property (p_prot_diff) else $error("other-level entry cost wrong");

  property p_v86_entry;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ctx.mode == iet_pkg::IET_MODE_V86 && i_ctx.gate != iet_pkg::IET_GATE_TASK |->
      int_clocks == (i_ctx.cache_miss ? 10'h063 : 10'h052);
  endproperty
  a_v86_entry: assert property (p_v86_entry) else $error("v86 entry cost wrong");

  property p_task_gate;
    @(posedge i_clk) disable iff (!i_resetn)
    i_ctx.mode != iet_pkg::IET_MODE_REAL && i_ctx.gate == iet_pkg::IET_GATE_TASK |->
      int_clocks == 10'(ts_clocks + (i_ctx.cache_miss ? 10'h028 : 10'h025));
  endproperty
  a_task_gate: assert property (p_task_gate) else $error("task gate entry cost wrong");

endmodule // iet_timing

// ==== verification/iet_timing_bench.sv ====
// iet_timing_bench: table-driven bench for the interrupt entry timing model
// assumes iet_pkg and iet_timing compiled first; assertions sit inside the design, the bench compares each row's outputs
`define CHK(what, exp, got) begin \
  n_tests++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("Error %s expected %h seen %h", what, exp, got); \
  end \
end
module iet_timing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic ev;
    logic [7:0] op;
    logic [7:0] typ;
    logic [2:0] evc;
    logic [10:0] ctx;
    logic [9:0] clk;
    logic [7:0] vec;
    logic [3:0] fl;
  } iet_row_s;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_op_valid = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic [7:0] i_type = 8'h00;
  logic i_ev_valid = 1'b0;
  iet_pkg::iet_event_e i_event = iet_pkg::IET_EV_NONE;
  iet_pkg::iet_ctx_s i_ctx = '0;
  logic o_done;
  iet_pkg::iet_res_s o_res;
  int mismatches = 0;
  int n_tests = 0;
  iet_row_s rows[$];

  iet_timing iet_timing_i (.i_clk(i_clk), .i_resetn(i_resetn), .i_op_valid(i_op_valid), .i_opcode(i_opcode),
    .i_type(i_type), .i_ev_valid(i_ev_valid), .i_event(i_event), .i_ctx(i_ctx), .o_done(o_done), .o_res(o_res));

  initial begin
    forever #50 i_clk = ~i_clk;
  end

  // flags: taken, return, bad, vector checked
  task automatic add(input logic ev, input logic [7:0] op, input logic [7:0] ty, input logic [2:0] e,
    input logic [10:0] c, input logic [9:0] n, input logic [7:0] v, input logic [3:0] f);
    iet_row_s r;
    r = '{ev, op, ty, e, c, n, v, f};
    rows.push_back(r);
  endtask

  task automatic drive(input iet_row_s r);
    i_op_valid = ~r.ev;
    i_ev_valid = r.ev;
    i_opcode = r.op;
    i_type = r.typ;
    i_event = iet_pkg::iet_event_e'(r.evc);
    i_ctx = r.ctx;
  endtask

  task automatic check(input iet_row_s r);
    `CHK("done", 1'b1, o_done)
    `CHK("clocks", r.clk, o_res.clocks)
    `CHK("return", r.fl[2], o_res.is_return)
    `CHK("bad_op", r.fl[1], o_res.bad_op)
    if (!r.fl[2]) `CHK("taken", r.fl[3], o_res.taken)
    if (r.fl[0]) `CHK("vector", r.vec, o_res.vector)
  endtask

  task automatic idle_zero();
    `CHK("idle done", 1'b0, o_done)
    `CHK("idle res", 21'h00000, o_res)
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    test_done();
  end

  initial begin
    add(1'h0, 8'hcc, 8'h00, 3'h0, {2'h0, 2'h0, 2'h0, 5'h00}, 10'h01a, 8'h03, 4'h9);
    add(1'h0, 8'hcd, 8'h21, 3'h0, {2'h0, 2'h0, 2'h0, 5'h00}, 10'h01e, 8'h21, 4'h9);
    add(1'h0, 8'hcd, 8'h40, 3'h0, {2'h1, 2'h0, 2'h0, 5'h00}, 10'h02c, 8'h40, 4'h9);
    add(1'h0, 8'hcd, 8'h41, 3'h0, {2'h2, 2'h0, 2'h0, 5'h00}, 10'h056, 8'h41, 4'h9);
    add(1'h0, 8'hce, 8'h00, 3'h0, {2'h0, 2'h0, 2'h0, 5'h00}, 10'h003, 8'h00, 4'h0);
    add(1'h0, 8'hce, 8'h00, 3'h0, {2'h0, 2'h0, 2'h0, 5'h11}, 10'h01e, 8'h04, 4'h9);
    add(1'h0, 8'h62, 8'h00, 3'h0, {2'h0, 2'h0, 2'h0, 5'h00}, 10'h007, 8'h00, 4'h0);
    add(1'h0, 8'h62, 8'h00, 3'h0, {2'h1, 2'h0, 2'h0, 5'h01}, 10'h00e, 8'h00, 4'h0);
    add(1'h0, 8'h62, 8'h00, 3'h0, {2'h0, 2'h0, 2'h0, 5'h02}, 10'h032, 8'h05, 4'h9);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h0, 2'h0, 2'h0, 5'h00}, 10'h00f, 8'h00, 4'h4);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h2, 2'h0, 2'h0, 5'h01}, 10'h017, 8'h00, 4'h4);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h1, 2'h0, 2'h0, 5'h00}, 10'h014, 8'h00, 4'h4);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h1, 2'h0, 2'h0, 5'h01}, 10'h01f, 8'h00, 4'h4);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h1, 2'h0, 2'h0, 5'h04}, 10'h024, 8'h00, 4'h4);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h1, 2'h0, 2'h0, 5'h05}, 10'h037, 8'h00, 4'h4);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h1, 2'h0, 2'h0, 5'h08}, 10'h0c2, 8'h00, 4'h4);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h1, 2'h0, 2'h0, 5'h09}, 10'h0fd, 8'h00, 4'h4);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h1, 2'h0, 2'h1, 5'h08}, 10'h0af, 8'h00, 4'h4);
    add(1'h0, 8'hcf, 8'h00, 3'h0, {2'h1, 2'h0, 2'h2, 5'h08}, 10'h0ac, 8'h00, 4'h4);
    add(1'h1, 8'h00, 8'h00, 3'h1, {2'h0, 2'h0, 2'h0, 5'h00}, 10'h025, 8'h00, 4'h9);
    add(1'h1, 8'h00, 8'h00, 3'h1, {2'h0, 2'h0, 2'h0, 5'h01}, 10'h027, 8'h00, 4'h9);
    add(1'h1, 8'h00, 8'h00, 3'h2, {2'h1, 2'h1, 2'h0, 5'h01}, 10'h05b, 8'h00, 4'h9);
    add(1'h1, 8'h00, 8'h00, 3'h3, {2'h1, 2'h0, 2'h0, 5'h00}, 10'h044, 8'h00, 4'h9);
    add(1'h1, 8'h00, 8'h00, 3'h1, {2'h2, 2'h1, 2'h0, 5'h00}, 10'h05d, 8'h00, 4'h9);
    add(1'h1, 8'h00, 8'h00, 3'h1, {2'h1, 2'h2, 2'h0, 5'h00}, 10'h0d2, 8'h00, 4'h9);
    add(1'h1, 8'h00, 8'h00, 3'h2, {2'h2, 2'h2, 2'h2, 5'h01}, 10'h0dc, 8'h00, 4'h9);
    add(1'h1, 8'h00, 8'h00, 3'h3, {2'h2, 2'h2, 2'h1, 5'h00}, 10'h0cc, 8'h00, 4'h9);
    add(1'h0, 8'h90, 8'h00, 3'h0, {2'h0, 2'h0, 2'h0, 5'h00}, 10'h000, 8'h00, 4'h2);
    add(1'h1, 8'h00, 8'h00, 3'h0, {2'h0, 2'h0, 2'h0, 5'h00}, 10'h000, 8'h00, 4'h2);
    repeat (12) @(negedge i_clk);
    idle_zero();
    i_resetn = 1'b1;
    @(negedge i_clk);
    // requests back to back, one per cycle
    foreach (rows[k]) begin
      drive(rows[k]);
      @(negedge i_clk);
      check(rows[k]);
    end
    i_op_valid = 1'b0;
    i_ev_valid = 1'b0;
    @(negedge i_clk);
    idle_zero();
    $display("test table done");
    // event beats a same-cycle breakpoint
    i_op_valid = 1'b1;
    i_opcode = 8'hcc;
    i_ev_valid = 1'b1;
    i_event = iet_pkg::IET_EV_NMI;
    @(negedge i_clk);
    i_op_valid = 1'b0;
    i_ev_valid = 1'b0;
    `CHK("clash clocks", 10'h01d, o_res.clocks)
    `CHK("clash vector", 8'h00, o_res.vector)
    @(negedge i_clk);
    idle_zero();
    $display("test clash done");
    // reset in mid-run clears a pending result
    drive(rows[15]);
    @(negedge i_clk);
    `CHK("pre-reset done", 1'b1, o_done)
    `CHK("pre-reset clocks", 10'h0c2, o_res.clocks)
    i_op_valid = 1'b0;
    i_resetn = 1'b0;
    #5 idle_zero();
    @(negedge i_clk);
    i_resetn = 1'b1;
    @(negedge i_clk);
    idle_zero();
    drive(rows[16]);
    @(negedge i_clk);
    check(rows[16]);
    i_op_valid = 1'b0;
    $display("test reset done");
    test_done();
  end
endmodule // iet_timing_bench
